/* src/bac_pkg.sv */
// Package: frame layout, register fields, reset values and timing for the converter link
package bac_pkg;
  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int FRAME_BITS = 16;
  localparam int WRITE_POS = 15;
  localparam int SEL1_POS = 14;
  localparam int SEL2_POS = 13;
  localparam int TRACK_EDGE = 15;
  localparam int RANGE_LOAD_EDGE = 11;
  localparam int CTRL_LOAD_EDGE = 15;
  localparam int RESULT_BITS = 12;
  // ****************************************************************
  // Control word fields (positions within the 16-bit input frame)
  // ****************************************************************
  localparam int CHAN_POS = 10;
  localparam int PM_HI_POS = 7;
  localparam int PM_LO_POS = 6;
  localparam int CODING_POS = 5;
  localparam int REF_POS = 4;
  localparam int RANGE_HI_POS = 12;
  // Range field codes
  localparam logic [1:0] RANGE_10V = 2'h0;
  localparam logic [1:0] RANGE_5V = 2'h1;
  localparam logic [1:0] RANGE_2V5 = 2'h2;
  localparam logic [1:0] RANGE_UNI10 = 2'h3;
  localparam logic [3:0] RANGE_RESET = 4'h0;
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_STANDBY = 2'h1;
  localparam logic [1:0] PM_AUTO_SD = 2'h2;
  localparam logic [1:0] PM_FULL_SD = 2'h3;
  localparam logic REF_RESET = 1'b0;
  localparam logic CODING_RESET = 1'b0;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 200;
  localparam int STANDBY_WAKE_US = 1;
  localparam int STANDBY_WAKE_CYC = STANDBY_WAKE_US * CLK_MHZ;
  localparam int QUIET_NS = 50;
  localparam int QUIET_CYC = (QUIET_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKEUP_US = 1;
  localparam int WAKEUP_CYC = WAKEUP_US * CLK_MHZ;
  localparam int SCLK_HALF_CYC = 8;
endpackage : bac_pkg

/* src/bac_link_if.sv */
// Interface: serial link between host controller and converter
interface bac_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout_o;
  logic dout_oe;
  logic dout;
  // Resolved wire level: pulled high while floating
  assign dout = dout_oe ? dout_o : 1'b1;
  modport device (input sclk, input cs_n, input din, output dout_o, output dout_oe);
  modport host (output sclk, output cs_n, output din, input dout);
endinterface : bac_link_if

/* src/bac_device.sv */
// Converter end: frame decode, registers, power modes and result shifting
// Functional notes
// - Four-bit write-only range register, two per channel
// - Write and select high mean range write
// - Range codes: 10V, 5V, 2.5V, unipolar 10V
// - Ranges reset to plus/minus ten volts
// - Stored range applied when channel converts
// - Reference bit resets 0, external reference
// - Host discards results after reference enable; bac_host passes every result to rx
// - Normal mode default, stays powered up
// - CS fall starts conversion; writes need flag
// - Host waits quiet interval between conversions
// - Full shutdown holds; exit at CS rise
// - Host waits wakeup interval after shutdown
// - Auto shutdown after conversion, track on CS
// - Auto standby keeps reference, wake 1 us
// - Host may use dummy frame at 20MHz
// - CS fall: hold, sample, drive output
// - Track at 15th fall, float at 16th
// - Early CS rise aborts and floats output
// - Input captured on falling SCLK, 3-bit decode
// - Control loads edge 15, range edge 11
// - Output: two zeros, channel, sign, result
// - Coding bit: 0 twos complement, 1 binary
// - Channel address bit selects next input
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
module bac_device
  import bac_pkg::*;
#(
  parameter int RES_W = 13
)(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Link
  bac_link_if.device link,
  // Analog side model: sampled signed value per channel
  input wire logic [RES_W-1:0] i_sample0,
  input wire logic [RES_W-1:0] i_sample1,
  // Status
  output logic [3:0] o_range,
  output logic [1:0] o_active_range,
  output logic o_ref_internal,
  output logic o_coding_binary,
  output logic [1:0] o_power_mode,
  output logic o_powered,
  output logic o_tracking,
  output logic o_frame_done
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] sclk_s;
  logic [1:0] cs_s;
  logic [1:0] din_s;
  logic sclk_d;
  logic cs_d;
  // Second stage only feeds logic; first stage stays private
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Idle levels of the pins, so release of reset shows no edge
      sclk_s <= 2'h3;
      cs_s <= 2'h3;
      din_s <= 2'h0;
      sclk_d <= 1'b1;
      cs_d <= 1'b1;
    end
    else
    begin
      sclk_s <= {sclk_s[0], link.sclk};
      cs_s <= {cs_s[0], link.cs_n};
      din_s <= {din_s[0], link.din};
      sclk_d <= sclk_s[1];
      cs_d <= cs_s[1];
    end
  end
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  assign sclk_fall = sclk_d & ~sclk_s[1];
  assign cs_fall = cs_d & ~cs_s[1];
  assign cs_rise = ~cs_d & cs_s[1];
  // ****************************************************************
  // Frame state
  // ****************************************************************
  logic active;
  logic [4:0] edge_cnt;
  logic [FRAME_BITS-1:0] in_sr;
  logic [FRAME_BITS-1:0] out_sr;
  logic [FRAME_BITS-1:0] next_in;
  logic [4:0] next_cnt;
  assign next_in = {in_sr[FRAME_BITS-2:0], din_s[1]};
  assign next_cnt = edge_cnt + 5'h1;
  // Decoded from the first three frame bits
  logic is_write;
  logic is_range;
  assign is_write = next_in[4'(RANGE_LOAD_EDGE-1)] == 1'b1;
  assign is_range = next_in[RANGE_LOAD_EDGE-2] & next_in[RANGE_LOAD_EDGE-3];
  // Control and range registers
  logic [3:0] range_reg;
  logic chan_addr;
  logic [1:0] pm;
  logic coding;
  logic ref_int;
  logic conv_chan;
  logic powered;
  logic wake_pending;
  // Frame sequencing: CS fall starts, 16 falls end, CS rise aborts
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      active <= 1'b0;
      edge_cnt <= 5'h0;
      in_sr <= '0;
      o_tracking <= 1'b1;
      o_frame_done <= 1'b0;
    end
    else
    begin
      o_frame_done <= 1'b0;
      if (cs_fall)
      begin
        active <= 1'b1;
        edge_cnt <= 5'h0;
        o_tracking <= 1'b0;
      end
      else if (cs_rise && active)
      begin
        active <= 1'b0;
        o_tracking <= 1'b1;
      end
      else if (active && sclk_fall)
      begin
        in_sr <= next_in;
        edge_cnt <= next_cnt;
        if (next_cnt == 5'(TRACK_EDGE))
          o_tracking <= 1'b1;
        if (next_cnt == 5'(FRAME_BITS))
        begin
          active <= 1'b0;
          o_frame_done <= 1'b1;
        end
      end
    end
  end
  // Range register: loaded on the 11th falling edge
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      range_reg <= RANGE_RESET;
    else if (active && sclk_fall && next_cnt == 5'(RANGE_LOAD_EDGE) && is_write && is_range)
      // Field lies four bits above the newest bit at the 11th fall
      range_reg <= next_in[RANGE_HI_POS-(FRAME_BITS-RANGE_LOAD_EDGE) -: 4];
  end
  // Control bits: loaded on the 15th falling edge
  logic [FRAME_BITS-1:0] ctrl_word;
  assign ctrl_word = {next_in[FRAME_BITS-2:0], 1'b0};
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      chan_addr <= 1'b0;
      pm <= PM_NORMAL;
      coding <= CODING_RESET;
      ref_int <= REF_RESET;
    end
    else if (active && sclk_fall && next_cnt == 5'(CTRL_LOAD_EDGE) && in_sr[13] && !in_sr[12]
             && in_sr[11] == 1'b0)
    begin
      chan_addr <= ctrl_word[CHAN_POS];
      pm <= {ctrl_word[PM_HI_POS], ctrl_word[PM_LO_POS]};
      coding <= ctrl_word[CODING_POS];
      ref_int <= ctrl_word[REF_POS];
    end
  end
  // Power state: full shutdown holds until a CS rise after a normal write
  logic [7:0] wake_cnt;
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      powered <= 1'b1;
      wake_pending <= 1'b0;
      wake_cnt <= 8'h0;
    end
    else
    begin
      if (o_frame_done && pm != PM_NORMAL)
        powered <= 1'b0;
      else if (cs_rise && pm == PM_NORMAL && !powered)
        powered <= 1'b1;
      else if (cs_fall && pm != PM_FULL_SD && !powered)
        wake_pending <= 1'b1;
      if (wake_pending)
      begin
        wake_cnt <= wake_cnt + 8'h1;
        if (wake_cnt == 8'(STANDBY_WAKE_CYC - 1))
        begin
          powered <= 1'b1;
          wake_pending <= 1'b0;
          wake_cnt <= 8'h0;
        end
      end
    end
  end
  // Result coding and output shifter
  logic [RES_W-1:0] raw;
  assign raw = chan_addr ? i_sample1 : i_sample0;
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      out_sr <= '0;
      conv_chan <= 1'b0;
      link.dout_oe <= 1'b0;
      link.dout_o <= 1'b0;
    end
    else if (cs_fall)
    begin
      conv_chan <= chan_addr;
      // Straight binary inverts the sign bit of the two's complement value
      // First leading zero goes out at once, so the shifter holds the rest
      out_sr <= {1'b0, chan_addr, coding ? {~raw[RES_W-1], raw[RES_W-2:0]} : raw, 1'b0};
      link.dout_oe <= 1'b1;
      link.dout_o <= 1'b0;
    end
    else if (cs_rise)
      link.dout_oe <= 1'b0;
    else if (active && sclk_fall)
    begin
      link.dout_o <= out_sr[FRAME_BITS-1];
      out_sr <= {out_sr[FRAME_BITS-2:0], 1'b0};
      if (next_cnt == 5'(FRAME_BITS))
        link.dout_oe <= 1'b0;
    end
  end
  // Status
  assign o_range = range_reg;
  assign o_active_range = conv_chan ? range_reg[1:0] : range_reg[3:2];
  assign o_ref_internal = ref_int;
  assign o_coding_binary = coding;
  assign o_power_mode = pm;
  assign o_powered = powered;
endmodule : bac_device

/* src/bac_host.sv */
// Host end: Avalon-MM command registers driving framed serial transfers
module bac_host
  import bac_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Link
  bac_link_if.host link
);
  // ****************************************************************
  // Registers: 0 tx word (write starts frame), 1 rx word, 2 status
  // ****************************************************************
  typedef enum {BH_IDLE, BH_LOW, BH_HIGH, BH_QUIET} bac_host_state_t;
  bac_host_state_t state;
  logic [FRAME_BITS-1:0] tx;
  logic [FRAME_BITS-1:0] rx;
  logic [4:0] bits;
  logic [7:0] tmr;
  logic [1:0] dq;
  logic busy;
  assign busy = state != BH_IDLE;
  // Reads take one wait state so data stands when waitrequest drops
  logic rd_ack;
  // Writes to tx stall while a frame runs
  assign o_waitrequest = (i_write && i_address == 2'h0 && busy) || (i_read && !rd_ack);
  // Read data registered in the wait cycle, held for the accept edge
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_readdata <= 32'h0;
      rd_ack <= 1'b0;
    end
    else
    begin
      rd_ack <= i_read && !rd_ack;
      if (i_read && !rd_ack)
        case (i_address)
          2'h1: o_readdata <= {16'h0, rx};
          2'h2: o_readdata <= {31'h0, busy};
          default: o_readdata <= 32'h0;
        endcase
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      dq <= 2'h0;
    else
      dq <= {dq[0], link.dout};
  end
  // Frame engine: CS low, 16 SCLK pulses, then quiet gap
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= BH_IDLE;
      tx <= '0;
      rx <= '0;
      bits <= 5'h0;
      tmr <= 8'h0;
      link.sclk <= 1'b1;
      link.cs_n <= 1'b1;
      link.din <= 1'b0;
    end
    else
    begin
      tmr <= tmr + 8'h1;
      case (state)
        BH_IDLE:
          if (i_write && i_address == 2'h0)
          begin
            tx <= i_writedata[FRAME_BITS-1:0];
            link.cs_n <= 1'b0;
            link.din <= i_writedata[FRAME_BITS-1];
            bits <= 5'h0;
            tmr <= 8'h0;
            state <= BH_HIGH;
          end
        BH_HIGH:
          if (tmr == 8'(SCLK_HALF_CYC))
          begin
            link.sclk <= 1'b0;
            rx <= {rx[FRAME_BITS-2:0], dq[1]};
            bits <= bits + 5'h1;
            tmr <= 8'h0;
            state <= BH_LOW;
          end
        BH_LOW:
          if (tmr == 8'(SCLK_HALF_CYC))
          begin
            link.sclk <= 1'b1;
            tmr <= 8'h0;
            tx <= {tx[FRAME_BITS-2:0], 1'b0};
            link.din <= tx[FRAME_BITS-2];
            if (bits == 5'(FRAME_BITS))
            begin
              link.cs_n <= 1'b1;
              state <= BH_QUIET;
            end
            else
              state <= BH_HIGH;
          end
        BH_QUIET:
          if (tmr == 8'(WAKEUP_CYC))
            state <= BH_IDLE;
        default:
          state <= BH_IDLE;
      endcase
    end
  end
endmodule : bac_host

/* verif/bac_link_chk.sv */
// Checker: timing relations on the host to converter serial link
module bac_link_chk
  import bac_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout_o,
  input wire logic dout_oe
);
  // ****************************************************************
  // Helper counters
  // ****************************************************************
  logic sclk_q;
  logic fall_now;
  logic [4:0] fall_cnt;
  logic [7:0] hi_cnt;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  // Serial clock fall as seen by the system clock
  assign fall_now = sclk_q & ~sclk;
  // Previous serial clock level
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n) sclk_q <= 1'b1;
    else sclk_q <= sclk;
  end
  // Falls inside a frame; cleared while deselected
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n) fall_cnt <= 5'h00;
    else if (cs_n) fall_cnt <= 5'h00;
    else if (fall_now) fall_cnt <= fall_cnt + 5'h01;
  end
  // Idle time; saturates so that long gaps never wrap to a short one
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n) hi_cnt <= 8'h00;
    else if (!cs_n) hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hFF) hi_cnt <= hi_cnt + 8'h01;
  end
  property p_quiet;
    $fell(cs_n) |-> hi_cnt >= 8'(QUIET_CYC);
  endproperty
  a_quiet: assert property (p_quiet) else $error("Frame began inside quiet gap");
  property p_sixteen;
    $rose(cs_n) |-> (fall_cnt + 5'(fall_now)) == 5'd16;
  endproperty
  a_sixteen: assert property (p_sixteen) else $error("Frame not 16 clocks");
  property p_din_stable;
    !cs_n && fall_now |-> $stable(din);
  endproperty
  a_din_stable: assert property (p_din_stable) else $error("Data moved at fall");
  property p_lead_zero;
    dout_oe && fall_cnt < 5'd2 |-> !dout_o;
  endproperty
  a_lead_zero: assert property (p_lead_zero) else $error("Leading bit not zero");
  property p_float16;
    (fall_cnt == 5'd16) [*5] |-> !dout_oe;
  endproperty
  a_float16: assert property (p_float16) else $error("Output driven after 16");
  property p_hold_oe;
    !cs_n && fall_cnt >= 5'd1 && fall_cnt <= 5'd15 |-> dout_oe;
  endproperty
  a_hold_oe: assert property (p_hold_oe) else $error("Output dropped in frame");
  property p_oe_on;
    $fell(cs_n) |-> ##[1:6] dout_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("Output not driven");
  property p_oe_off;
    cs_n [*6] |-> !dout_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("Output driven idle");
endmodule : bac_link_chk

/* verif/bipolar_adc_serial_control_test.sv */
// Testbench: both link ends, Avalon commands, wire checks and abort cases
module bipolar_adc_serial_control_test
  import bac_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [1:0] i_address = 2'h0;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic [3:0] range;
  logic [3:0] range2;
  logic [1:0] act_range;
  logic ref_int;
  logic coding_bin;
  logic [1:0] pm;
  logic powered;
  logic tracking;
  logic tracking2;
  logic frame_done;
  logic [15:0] rx;
  int done_cnt = 0;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  bac_link_if link();
  bac_link_if link2();
  // ****************************************************************
  // Design ends and checker
  // ****************************************************************
  bac_host u_bac_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .link(link.host));
  bac_device u_bac_device (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .link(link.device),
    .i_sample0(13'h1234), .i_sample1(13'h0ABC), .o_range(range),
    .o_active_range(act_range), .o_ref_internal(ref_int), .o_coding_binary(coding_bin),
    .o_power_mode(pm), .o_powered(powered), .o_tracking(tracking),
    .o_frame_done(frame_done));
  // Second device driven by the bench so frames can be cut short
  bac_device u_bac_device_2 (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .link(link2.device),
    .i_sample0(13'h0000), .i_sample1(13'h0000), .o_range(range2), .o_active_range(),
    .o_ref_internal(), .o_coding_binary(), .o_power_mode(), .o_powered(),
    .o_tracking(tracking2), .o_frame_done());
  bac_link_chk u_bac_link_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .sclk(link.sclk),
    .cs_n(link.cs_n), .din(link.din), .dout_o(link.dout_o), .dout_oe(link.dout_oe));
  // System clock
  always #2.5 i_mclk = ~i_mclk;
  // Completed frames on the host link; the pulse lasts one cycle
  always @(posedge i_mclk)
  begin
    if (frame_done === 1'b1)
      done_cnt++;
  end
  // Ceiling well above the roughly 7300 cycles the sequence needs
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      $display("ERROR %0t: timeout", $time);
      finish_test();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One Avalon cycle; request held until an edge samples waitrequest low
  task av_xfer(input logic wr, input logic [1:0] a, input logic [31:0] d,
    output logic [31:0] q);
    i_address <= a;
    i_writedata <= d;
    i_write <= wr;
    i_read <= !wr;
    @(posedge i_mclk);
    while (o_waitrequest !== 1'b0)
      @(posedge i_mclk);
    // Read data taken at the accepting edge, then the request drops
    q = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    // Idle edge so a following call never reassigns in this step
    @(posedge i_mclk);
  endtask : av_xfer
  task frame(input logic [15:0] word);
    logic [31:0] q;
    int d0;
    d0 = done_cnt;
    av_xfer(1'b1, 2'h0, {16'h0000, word}, q);
    repeat (4) @(posedge i_mclk);
    q = 32'h1;
    while (q[0] !== 1'b0) av_xfer(1'b0, 2'h2, 32'h0, q);
    av_xfer(1'b0, 2'h1, 32'h0, q);
    rx = q[15:0];
    chk(16'(done_cnt - d0), 16'h0001);
  endtask : frame
  // Hand-made frame at an 80 ns serial clock, cut after the given falls
  task drive2(input logic [15:0] word, input int falls);
    link2.cs_n <= 1'b0;
    link2.din <= word[15];
    for (int i = 1; i <= falls; i++)
    begin
      repeat (8) @(posedge i_mclk);
      link2.sclk <= 1'b0;
      repeat (8) @(posedge i_mclk);
      link2.sclk <= 1'b1;
      link2.din <= word[15-i];
    end
    chk(16'(link2.dout_oe), 16'h0001);
    chk(16'(tracking2), 16'h0000);
    link2.cs_n <= 1'b1;
    repeat (300) @(posedge i_mclk);
    chk(16'({link2.dout_oe, link2.dout}), 16'h0001);
  endtask : drive2
  task t_reset();
    logic [31:0] q;
    chk(16'({range, ref_int, coding_bin, pm, tracking, link.dout_oe, link.dout}),
      16'h0005);
    av_xfer(1'b1, 2'h3, 32'h0000E000, q);
    av_xfer(1'b0, 2'h3, 32'h0, q);
    chk(16'(link.cs_n), 16'h0001);
  endtask : t_reset
  task t_chan();
    frame(16'hEE00);
    chk(16'(range), 16'h0007);
    frame(16'h8430);
    chk(16'({ref_int, coding_bin}), 16'h0003);
    frame(16'h0000);
    chk(rx, 16'h3ABC);
    chk(16'({act_range, ref_int, coding_bin, range}), 16'h00F7);
    frame(16'h8000);
    frame(16'h0000);
    chk(rx, 16'h1234);
    chk(16'(act_range), 16'h0001);
  endtask : t_chan
  // Every power mode, ending back in normal mode
  task t_power();
    logic [1:0] m;
    for (int i = 3; i >= 0; i--)
    begin
      m = 2'(i);
      frame({8'h80, m, 6'h00});
      repeat (WAKEUP_CYC) @(posedge i_mclk);
      chk(16'({pm, powered}), 16'({m, m == PM_NORMAL}));
    end
    // Out of full shutdown the closing CS rise alone powers up
    frame({8'h80, PM_FULL_SD, 6'h00});
    frame({8'h80, PM_NORMAL, 6'h00});
    chk(16'({pm, powered}), 16'h0001);
  endtask : t_power
  task t_abort();
    drive2(16'hE600, 10);
    chk(16'(range2), 16'h0000);
    drive2(16'hE600, 12);
    chk(16'(range2), 16'h0003);
  endtask : t_abort
  task finish_test();
    $display("Errors %0d, checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // Main sequence
  initial
  begin
    link2.sclk = 1'b1;
    link2.cs_n = 1'b1;
    link2.din = 1'b0;
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (20) @(posedge i_mclk);
    t_reset();
    t_chan();
    t_power();
    t_abort();
    finish_test();
  end
endmodule : bipolar_adc_serial_control_test
